// File: bspc_pkg.sv
package bspc_pkg;

  // ---------------------------------------------------------------------
  // Widths and depths
  // ---------------------------------------------------------------------
  localparam int BSPC_DATA_W = 8;
  localparam int BSPC_CH_W = 8;
  localparam int BSPC_BUF_DEPTH = 2;

  // A decoded beat as it travels through the output buffer.
  localparam int BSPC_BEAT_W = BSPC_DATA_W + BSPC_CH_W + 2;
  localparam int BSPC_BEAT_EOP_BIT = 0;
  localparam int BSPC_BEAT_SOP_BIT = 1;
  localparam int BSPC_BEAT_CH_LSB = 2;
  localparam int BSPC_BEAT_DATA_LSB = BSPC_BEAT_CH_LSB + BSPC_CH_W;

  // ---------------------------------------------------------------------
  // Reserved byte codes, escape xor mask and zero byte
  // ---------------------------------------------------------------------
  localparam logic [7:0] BSPC_CODE_SOP = 8'h7A;
  localparam logic [7:0] BSPC_CODE_EOP = 8'h7B;
  localparam logic [7:0] BSPC_CODE_CHI = 8'h7C;
  localparam logic [7:0] BSPC_CODE_ESC = 8'h7D;
  localparam logic [7:0] BSPC_ESC_XOR = 8'h20;
  localparam logic [7:0] BSPC_ZERO_BYTE = 8'h00;

  // Encoder output steps for one input beat.
  typedef enum logic [2:0] {
    ES_START, ES_CHI, ES_CHE, ES_CHN, ES_SOP, ES_EOP, ES_ESC, ES_DAT
  } bspc_enc_step_t;

  function automatic logic bspc_is_special(input logic [7:0] b);
    return (b == BSPC_CODE_SOP) || (b == BSPC_CODE_EOP) ||
           (b == BSPC_CODE_CHI) || (b == BSPC_CODE_ESC);
  endfunction

endpackage

// File: bspc_buf.sv
`timescale 1ns/1ps
module bspc_buf
  import bspc_pkg::*;
#(
  parameter int W = BSPC_BEAT_W,
  parameter int DEPTH = BSPC_BUF_DEPTH
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic i_in_valid,
  input wire logic [W-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [W-1:0] o_out_data,
  input wire logic i_out_ready
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [CW-1:0] cnt_r;
  logic empty;
  logic full;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    return (p == LAST_PTR) ? '0 : p + AW'(1);
  endfunction

  // Both handshakes are gated by the clock enable so that no beat
  // moves while the block is frozen.
  assign empty = (cnt_r == '0);
  assign full = (cnt_r == FULL_CNT);
  assign o_in_ready = i_clk_en && !full;
  assign o_out_valid = i_clk_en && !empty;
  assign o_out_data = mem_r[rd_ptr_r];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else if (i_clk_en) begin
      if (push) begin
        mem_r[wr_ptr_r] <= i_in_data;
        wr_ptr_r <= ptr_inc(wr_ptr_r);
      end
      if (pop) begin
        rd_ptr_r <= ptr_inc(rd_ptr_r);
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + CW'(1);
      end else if (pop && !push) begin
        cnt_r <= cnt_r - CW'(1);
      end
    end
  end

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  property p_buf_hold;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (!empty && !(i_out_ready && i_clk_en)) |=>
      (!empty && $stable(o_out_data));
  endproperty
  a_buf_hold: assert property (p_buf_hold)
    else $error("Buffered word changed or vanished while stalled.");

  property p_buf_fills;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    full;
  endproperty
  c_buf_fills: cover property (p_buf_fills);

endmodule

// File: bspc_dec.sv
`timescale 1ns/1ps
module bspc_dec
  import bspc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic i_byte_valid,
  input wire logic [BSPC_DATA_W-1:0] i_byte,
  output logic o_byte_ready,
  output logic o_push,
  output logic [BSPC_BEAT_W-1:0] o_push_beat,
  input wire logic i_push_ready
);

  logic esc_r;
  logic sop_pend_r;
  logic eop_pend_r;
  logic chan_pend_r;
  logic [BSPC_CH_W-1:0] ch_r;
  logic in_fire;
  logic is_code;
  logic [BSPC_DATA_W-1:0] payload;
  logic take_ch;

  // Marker bytes are accepted only when the buffer could also take a
  // payload byte; this keeps the ready path free of data decoding.
  assign o_byte_ready = i_push_ready;
  assign in_fire = i_byte_valid && i_push_ready;
  assign is_code = !esc_r && bspc_is_special(i_byte);
  assign payload = esc_r ? (i_byte ^ BSPC_ESC_XOR) : i_byte;
  assign take_ch = in_fire && !is_code && chan_pend_r;
  assign o_push = in_fire && !is_code && !chan_pend_r;
  assign o_push_beat = {payload, ch_r, sop_pend_r, eop_pend_r};

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      esc_r <= 1'b0;
      sop_pend_r <= 1'b0;
      eop_pend_r <= 1'b0;
      chan_pend_r <= 1'b0;
      ch_r <= '0;
    end else if (i_clk_en && in_fire) begin
      esc_r <= is_code && (i_byte == BSPC_CODE_ESC);
      if (is_code && (i_byte == BSPC_CODE_SOP)) begin
        sop_pend_r <= 1'b1;
      end else if (o_push) begin
        sop_pend_r <= 1'b0;
      end
      if (is_code && (i_byte == BSPC_CODE_EOP)) begin
        eop_pend_r <= 1'b1;
      end else if (o_push) begin
        eop_pend_r <= 1'b0;
      end
      if (is_code && (i_byte == BSPC_CODE_CHI)) begin
        chan_pend_r <= 1'b1;
      end else if (take_ch) begin
        chan_pend_r <= 1'b0;
      end
      if (take_ch) begin
        ch_r <= payload;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  property p_dec_esc;
    (in_fire && esc_r && !chan_pend_r) |->
      (o_push && (o_push_beat[BSPC_BEAT_DATA_LSB +: BSPC_DATA_W] ==
                  (i_byte ^ BSPC_ESC_XOR)));
  endproperty
  a_dec_esc: assert property (p_dec_esc)
    else $error("Escaped byte not delivered with the xor applied.");

  property p_dec_drop;
    (in_fire && !esc_r && bspc_is_special(i_byte)) |-> !o_push;
  endproperty
  a_dec_drop: assert property (p_dec_drop)
    else $error("Marker byte produced an output beat.");

  property p_dec_prio;
    (in_fire && esc_r && (i_byte == BSPC_CODE_CHI)) |=>
      !chan_pend_r || $past(chan_pend_r);
  endproperty
  a_dec_prio: assert property (p_dec_prio)
    else $error("Escaped code acted as a channel marker.");

  property p_dec_sop;
    (in_fire && !esc_r && (i_byte == BSPC_CODE_SOP)) ##1
      (in_fire && !esc_r && !bspc_is_special(i_byte) && !chan_pend_r)
      |-> o_push_beat[BSPC_BEAT_SOP_BIT];
  endproperty
  a_dec_sop: assert property (p_dec_sop)
    else $error("Start marker did not flag the next payload byte.");

  property p_dec_eop;
    (in_fire && !esc_r && (i_byte == BSPC_CODE_EOP)) |=>
      eop_pend_r;
  endproperty
  a_dec_eop: assert property (p_dec_eop)
    else $error("End marker was not remembered.");

  property p_dec_single;
    (in_fire && !esc_r && (i_byte == BSPC_CODE_SOP)) ##1
      (in_fire && !esc_r && (i_byte == BSPC_CODE_EOP)) ##1
      (in_fire && !esc_r && !bspc_is_special(i_byte) && !chan_pend_r)
      |-> (o_push && o_push_beat[BSPC_BEAT_SOP_BIT] &&
           o_push_beat[BSPC_BEAT_EOP_BIT]);
  endproperty
  a_dec_single: assert property (p_dec_single)
    else $error("Single beat packet lost one of its flags.");

  property p_dec_ch;
    take_ch |=> (ch_r == $past(payload)) && !chan_pend_r;
  endproperty
  a_dec_ch: assert property (p_dec_ch)
    else $error("Channel byte not adopted.");

endmodule

// File: bspc_codec.sv
`timescale 1ns/1ps
// Behaviour
// - Every stream beat carries one 8-bit symbol.
// - Channel numbers up to 255 are carried.
// - Packet flags exist only on packet sides.
// - Decoder priority: escape, start, end, channel.
// - Decoder drops 0x7d, xors next byte 0x20.
// - Decoder drops 0x7a, flags next payload start.
// - Decoder drops 0x7b, flags next payload end.
// - Single beat packet raises both flags together.
// - Decoder drops 0x7c, next plain byte sets channel.
// - Encoder packet start: 0x7c, channel, 0x7a.
// - Encoder puts 0x7b before the last byte.
// - Encoder marks mid-packet channel changes.
// - Encoder escapes reserved payload bytes with 0x7d.
module bspc_codec
  import bspc_pkg::*;
#(
  parameter int BUF_DEPTH = BSPC_BUF_DEPTH
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic i_enc_valid,
  output logic o_enc_ready,
  input wire logic [BSPC_DATA_W-1:0] i_enc_data,
  input wire logic [BSPC_CH_W-1:0] i_enc_channel,
  input wire logic i_enc_sop,
  input wire logic i_enc_eop,
  output logic o_enc_byte_valid,
  input wire logic i_enc_byte_ready,
  output logic [BSPC_DATA_W-1:0] o_enc_byte,
  input wire logic i_dec_byte_valid,
  output logic o_dec_byte_ready,
  input wire logic [BSPC_DATA_W-1:0] i_dec_byte,
  output logic o_dec_valid,
  input wire logic i_dec_ready,
  output logic [BSPC_DATA_W-1:0] o_dec_data,
  output logic [BSPC_CH_W-1:0] o_dec_channel,
  output logic o_dec_sop,
  output logic o_dec_eop
);

  // ---------------------------------------------------------------------
  // Encoder sequencing
  // ---------------------------------------------------------------------
  // One input beat is expanded into a short run of output bytes. The
  // current step is the registered step, except at the start of a beat,
  // where the first step is decoded straight from the input so that a
  // plain payload byte costs no extra cycle.

  function automatic bspc_enc_step_t tail_step(input logic sop,
                                               input logic eop,
                                               input logic data_esc);
    return sop ? ES_SOP : eop ? ES_EOP : data_esc ? ES_ESC : ES_DAT;
  endfunction

  function automatic bspc_enc_step_t step_after(input bspc_enc_step_t s,
                                                input logic need_ch,
                                                input logic chan_esc,
                                                input logic sop,
                                                input logic eop,
                                                input logic data_esc);
    bspc_enc_step_t n;
    n = ES_START;
    unique case (s)
      ES_START: begin
        n = need_ch ? ES_CHI : tail_step(sop, eop, data_esc);
      end
      ES_CHI: begin
        n = chan_esc ? ES_CHE : ES_CHN;
      end
      ES_CHE: begin
        n = ES_CHN;
      end
      ES_CHN: begin
        n = tail_step(sop, eop, data_esc);
      end
      ES_SOP: begin
        n = tail_step(1'b0, eop, data_esc);
      end
      ES_EOP: begin
        n = tail_step(1'b0, 1'b0, data_esc);
      end
      ES_ESC: begin
        n = ES_DAT;
      end
      ES_DAT: begin
        n = ES_START;
      end
    endcase
    return n;
  endfunction

  bspc_enc_step_t st_r;
  bspc_enc_step_t st_nxt;
  bspc_enc_step_t cur_step;
  logic [BSPC_CH_W-1:0] cur_ch_r;
  logic [BSPC_CH_W-1:0] cur_ch_nxt;
  logic in_pkt_r;
  logic in_pkt_nxt;
  logic need_ch;
  logic chan_esc;
  logic data_esc;
  logic [BSPC_DATA_W-1:0] enc_byte;
  logic enc_push;
  logic enc_accept;
  logic ebuf_in_ready;

  // A start always announces the channel; inside a packet only a change
  // of channel does.
  assign need_ch = i_enc_sop ||
                   (in_pkt_r && (i_enc_channel != cur_ch_r));
  assign chan_esc = bspc_is_special(i_enc_channel);
  assign data_esc = bspc_is_special(i_enc_data);

  assign cur_step = (st_r == ES_START) ?
                    step_after(ES_START, need_ch, chan_esc, i_enc_sop,
                               i_enc_eop, data_esc) :
                    st_r;

  // The byte side never carries flags: every marker becomes a byte.
  assign enc_byte =
    (cur_step == ES_CHI) ? BSPC_CODE_CHI :
    (cur_step == ES_CHE) ? BSPC_CODE_ESC :
    (cur_step == ES_CHN) ?
      (chan_esc ? (i_enc_channel ^ BSPC_ESC_XOR) : i_enc_channel) :
    (cur_step == ES_SOP) ? BSPC_CODE_SOP :
    (cur_step == ES_EOP) ? BSPC_CODE_EOP :
    (cur_step == ES_ESC) ? BSPC_CODE_ESC :
    (cur_step == ES_DAT) ?
      (data_esc ? (i_enc_data ^ BSPC_ESC_XOR) : i_enc_data) :
    BSPC_ZERO_BYTE;

  // The input is held until its payload byte itself goes out, so
  // inserted bytes never let a beat slip past or get reordered.
  assign enc_push = i_enc_valid && ebuf_in_ready;
  assign enc_accept = enc_push && (cur_step == ES_DAT);
  assign o_enc_ready = ebuf_in_ready && (cur_step == ES_DAT);

  assign st_nxt = enc_push ?
                  step_after(cur_step, need_ch, chan_esc, i_enc_sop,
                             i_enc_eop, data_esc) :
                  st_r;
  assign cur_ch_nxt = (enc_push && (cur_step == ES_CHN)) ?
                      i_enc_channel : cur_ch_r;
  assign in_pkt_nxt = enc_accept ? !i_enc_eop : in_pkt_r;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= ES_START;
      cur_ch_r <= '0;
      in_pkt_r <= 1'b0;
    end else if (i_clk_en) begin
      st_r <= st_nxt;
      cur_ch_r <= cur_ch_nxt;
      in_pkt_r <= in_pkt_nxt;
    end
  end

  // ---------------------------------------------------------------------
  // Buffers on both output paths
  // ---------------------------------------------------------------------
  // A stall downstream fills the buffer and then drops the ready that
  // steers the encoder and decoder, so nothing is lost.

  bspc_buf #(
    .W(BSPC_DATA_W),
    .DEPTH(BUF_DEPTH)
  ) u_enc_buf (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_clk_en(i_clk_en),
    .i_in_valid(i_enc_valid),
    .i_in_data(enc_byte),
    .o_in_ready(ebuf_in_ready),
    .o_out_valid(o_enc_byte_valid),
    .o_out_data(o_enc_byte),
    .i_out_ready(i_enc_byte_ready)
  );

  logic dec_push;
  logic [BSPC_BEAT_W-1:0] dec_push_beat;
  logic dbuf_in_ready;
  logic [BSPC_BEAT_W-1:0] dbuf_out_beat;

  bspc_dec u_dec (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_clk_en(i_clk_en),
    .i_byte_valid(i_dec_byte_valid),
    .i_byte(i_dec_byte),
    .o_byte_ready(o_dec_byte_ready),
    .o_push(dec_push),
    .o_push_beat(dec_push_beat),
    .i_push_ready(dbuf_in_ready)
  );

  bspc_buf #(
    .W(BSPC_BEAT_W),
    .DEPTH(BUF_DEPTH)
  ) u_dec_buf (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_clk_en(i_clk_en),
    .i_in_valid(dec_push),
    .i_in_data(dec_push_beat),
    .o_in_ready(dbuf_in_ready),
    .o_out_valid(o_dec_valid),
    .o_out_data(dbuf_out_beat),
    .i_out_ready(i_dec_ready)
  );

  // Packet flags and channel appear only on this side of the decoder.
  assign o_dec_data = dbuf_out_beat[BSPC_BEAT_DATA_LSB +: BSPC_DATA_W];
  assign o_dec_channel = dbuf_out_beat[BSPC_BEAT_CH_LSB +: BSPC_CH_W];
  assign o_dec_sop = dbuf_out_beat[BSPC_BEAT_SOP_BIT];
  assign o_dec_eop = dbuf_out_beat[BSPC_BEAT_EOP_BIT];

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  // Remembers the byte most recently handed to the output buffer.
  logic [BSPC_DATA_W-1:0] last_byte_r;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      last_byte_r <= BSPC_ZERO_BYTE;
    end else if (i_clk_en && enc_push) begin
      last_byte_r <= enc_byte;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  property p_enc_hold;
    (enc_push && (cur_step != ES_DAT)) |->
      !o_enc_ready ##1 (st_r != ES_START);
  endproperty
  a_enc_hold: assert property (p_enc_hold)
    else $error("Input taken while an inserted byte went out.");

  property p_enc_head;
    (st_r == ES_START && i_enc_valid && i_enc_sop && enc_push) |->
      (enc_byte == BSPC_CODE_CHI) ##1
      (st_r == ES_CHE || st_r == ES_CHN);
  endproperty
  a_enc_head: assert property (p_enc_head)
    else $error("Packet start not opened with a channel marker.");

  property p_enc_sop;
    (enc_accept && i_enc_sop && !i_enc_eop && !data_esc) |->
      (last_byte_r == BSPC_CODE_SOP);
  endproperty
  a_enc_sop: assert property (p_enc_sop)
    else $error("Start marker missing before first payload byte.");

  property p_enc_eop;
    (enc_accept && i_enc_eop && !data_esc) |->
      (last_byte_r == BSPC_CODE_EOP);
  endproperty
  a_enc_eop: assert property (p_enc_eop)
    else $error("End marker missing before last payload byte.");

  property p_enc_esc;
    (enc_accept && data_esc) |->
      ((last_byte_r == BSPC_CODE_ESC) &&
       (enc_byte == (i_enc_data ^ BSPC_ESC_XOR)));
  endproperty
  a_enc_esc: assert property (p_enc_esc)
    else $error("Reserved payload byte not escaped.");

  property p_enc_chg;
    (st_r == ES_START && i_enc_valid && in_pkt_r && !i_enc_sop &&
     (i_enc_channel != cur_ch_r)) |->
      (cur_step == ES_CHI) && (enc_byte == BSPC_CODE_CHI);
  endproperty
  a_enc_chg: assert property (p_enc_chg)
    else $error("Channel change inside a packet not marked.");

  property p_enc_ch_upd;
    (enc_push && (cur_step == ES_CHN)) |=>
      (cur_ch_r == $past(i_enc_channel));
  endproperty
  a_enc_ch_upd: assert property (p_enc_ch_upd)
    else $error("Announced channel not remembered.");

  property p_cov_esc;
    enc_accept && data_esc;
  endproperty
  c_cov_esc: cover property (p_cov_esc);

  property p_cov_chg;
    enc_push && (cur_step == ES_CHI) && !i_enc_sop;
  endproperty
  c_cov_chg: cover property (p_cov_chg);

  property p_cov_single;
    o_dec_valid && i_dec_ready && o_dec_sop && o_dec_eop;
  endproperty
  c_cov_single: cover property (p_cov_single);

endmodule

// File: bspc_sink_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------
// Downstream stream sink
// ---------------------------------------------------------------------
// Slow mode takes one beat in four, which is enough to fill the buffer.
module bspc_sink_model #(
  parameter int W = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_slow,
  input wire logic i_valid,
  input wire logic [W-1:0] i_data,
  output logic o_ready
);
  logic [W-1:0] seen[$];
  logic [1:0] cnt_r;
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= 2'h0;
    end else begin
      cnt_r <= cnt_r + 2'h1;
      if (i_valid && o_ready) seen.push_back(i_data);
    end
  end
  assign o_ready = i_rst_n && (!i_slow || cnt_r == 2'h3);
endmodule

// File: byte_stream_packet_codec_bench.sv
`timescale 1ns/1ps
module byte_stream_packet_codec_bench;
  import bspc_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_clk_en = 1'b1;
  logic i_enc_valid = 1'b0;
  logic [7:0] i_enc_data = 8'h00;
  logic [7:0] i_enc_channel = 8'h00;
  logic i_enc_sop = 1'b0;
  logic i_enc_eop = 1'b0;
  logic i_dec_byte_valid = 1'b0;
  logic [7:0] i_dec_byte = 8'h00;
  logic enc_slow = 1'b0;
  logic dec_slow = 1'b0;
  logic o_enc_ready, o_enc_byte_valid, i_enc_byte_ready;
  logic o_dec_byte_ready, o_dec_valid, i_dec_ready, o_dec_sop, o_dec_eop;
  logic [7:0] o_enc_byte, o_dec_data, o_dec_channel;
  logic [7:0] enc_exp[$];
  logic [17:0] dec_exp[$];
  int bad_count = 0;
  int checks = 0;
  int wait_n;
  logic in_pkt = 1'b0;
  logic [7:0] last_ch = 8'h00;

  always #12.5 i_ref_clk = ~i_ref_clk;

  bspc_codec bspc_codec_inst (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_clk_en(i_clk_en), .i_enc_valid(i_enc_valid),
    .o_enc_ready(o_enc_ready), .i_enc_data(i_enc_data),
    .i_enc_channel(i_enc_channel), .i_enc_sop(i_enc_sop),
    .i_enc_eop(i_enc_eop), .o_enc_byte_valid(o_enc_byte_valid),
    .i_enc_byte_ready(i_enc_byte_ready), .o_enc_byte(o_enc_byte),
    .i_dec_byte_valid(i_dec_byte_valid),
    .o_dec_byte_ready(o_dec_byte_ready), .i_dec_byte(i_dec_byte),
    .o_dec_valid(o_dec_valid), .i_dec_ready(i_dec_ready),
    .o_dec_data(o_dec_data), .o_dec_channel(o_dec_channel),
    .o_dec_sop(o_dec_sop), .o_dec_eop(o_dec_eop));
  bspc_sink_model enc_sink (.i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n), .i_slow(enc_slow), .i_valid(o_enc_byte_valid),
    .i_data(o_enc_byte), .o_ready(i_enc_byte_ready));
  bspc_sink_model #(.W(18)) dec_sink (.i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n), .i_slow(dec_slow), .i_valid(o_dec_valid),
    .i_data({o_dec_data, o_dec_channel, o_dec_sop, o_dec_eop}),
    .o_ready(i_dec_ready));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // -------------------------------------------------------------------
  // Encoder side
  // -------------------------------------------------------------------
  task automatic put_esc(input logic [7:0] b);
    if (b >= 8'h7A && b <= 8'h7D) begin
      enc_exp.push_back(8'h7D);
      enc_exp.push_back(b ^ 8'h20);
    end else begin
      enc_exp.push_back(b);
    end
  endtask

  // The expected bytes are queued before the beat is offered.
  task automatic enc_beat(input logic [7:0] d, input logic [7:0] ch,
                          input logic s, input logic e);
    if (s || (in_pkt && ch != last_ch)) begin
      enc_exp.push_back(8'h7C);
      put_esc(ch);
    end
    if (s) enc_exp.push_back(8'h7A);
    if (e) enc_exp.push_back(8'h7B);
    put_esc(d);
    in_pkt = !e;
    last_ch = ch;
    @(negedge i_ref_clk);
    i_enc_valid = 1'b1;
    i_enc_data = d;
    i_enc_channel = ch;
    i_enc_sop = s;
    i_enc_eop = e;
    wait_n = 0;
    #1;
    while (o_enc_ready !== 1'b1) begin
      @(negedge i_ref_clk);
      #1;
      wait_n++;
    end
    @(posedge i_ref_clk);
  endtask

  task automatic enc_check;
    int n;
    @(negedge i_ref_clk);
    i_enc_valid = 1'b0;
    i_enc_data = ~i_enc_data;
    n = 0;
    while (enc_sink.seen.size() < enc_exp.size() && n < 300) begin
      @(posedge i_ref_clk);
      n++;
    end
    repeat (10) @(posedge i_ref_clk);
    check(enc_sink.seen.size(), enc_exp.size());
    foreach (enc_exp[k]) check(enc_sink.seen[k], enc_exp[k]);
    enc_sink.seen.delete();
    enc_exp.delete();
  endtask

  task automatic t_enc_stall;
    enc_slow = 1'b1;
    enc_beat(8'h41, 8'h01, 1'b1, 1'b0);
    enc_beat(8'h7A, 8'h01, 1'b0, 1'b0);
    enc_beat(8'h42, 8'h01, 1'b0, 1'b1);
    enc_check;
    enc_slow = 1'b0;
  endtask

  task automatic t_enc_inserts;
    enc_beat(8'h10, 8'h7C, 1'b1, 1'b0);
    check(wait_n, 4);
    enc_beat(8'h7D, 8'h7C, 1'b0, 1'b0);
    check(wait_n, 1);
    enc_beat(8'h20, 8'hFF, 1'b0, 1'b0);
    check(wait_n, 2);
    enc_beat(8'h7B, 8'hFF, 1'b0, 1'b1);
    check(wait_n, 2);
    enc_beat(8'h55, 8'h02, 1'b1, 1'b1);
    check(wait_n, 4);
    enc_check;
  endtask

  // -------------------------------------------------------------------
  // Decoder side
  // -------------------------------------------------------------------
  task automatic dec_send(input logic [7:0] b);
    @(negedge i_ref_clk);
    i_dec_byte_valid = 1'b1;
    i_dec_byte = b;
    #1;
    while (o_dec_byte_ready !== 1'b1) begin
      @(negedge i_ref_clk);
      #1;
    end
    @(posedge i_ref_clk);
  endtask

  task automatic t_dec(input logic slow);
    logic [7:0] bytes[22] = '{8'h7C, 8'h01, 8'h7A, 8'h41, 8'h7D, 8'h5A,
      8'h7B, 8'h42, 8'h7C, 8'h7D, 8'h5C, 8'h7A, 8'h7B, 8'h33,
      8'h7C, 8'h7A, 8'h03, 8'h44, 8'h7D, 8'h7C, 8'h7B, 8'h45};
    int n;
    dec_slow = slow;
    dec_exp = '{{8'h41, 8'h01, 2'b10}, {8'h7A, 8'h01, 2'b00},
      {8'h42, 8'h01, 2'b01}, {8'h33, 8'h7C, 2'b11},
      {8'h44, 8'h03, 2'b10}, {8'h5C, 8'h03, 2'b00},
      {8'h45, 8'h03, 2'b01}};
    foreach (bytes[k]) dec_send(bytes[k]);
    @(negedge i_ref_clk);
    i_dec_byte_valid = 1'b0;
    i_dec_byte = ~i_dec_byte;
    n = 0;
    while (dec_sink.seen.size() < dec_exp.size() && n < 300) begin
      @(posedge i_ref_clk);
      n++;
    end
    repeat (10) @(posedge i_ref_clk);
    check(dec_sink.seen.size(), dec_exp.size());
    foreach (dec_exp[k]) check(dec_sink.seen[k], dec_exp[k]);
    dec_sink.seen.delete();
    dec_slow = 1'b0;
  endtask
  // The list above also through its expected beats.

  task automatic t_clk_en_low;
    @(negedge i_ref_clk);
    i_clk_en = 1'b0;
    i_enc_valid = 1'b1;
    i_enc_sop = 1'b0;
    i_enc_eop = 1'b0;
    i_dec_byte_valid = 1'b1;
    #1;
    check({o_enc_ready, o_dec_byte_ready}, 2'b00);
    repeat (3) @(negedge i_ref_clk);
    i_clk_en = 1'b1;
    i_enc_valid = 1'b0;
    i_dec_byte_valid = 1'b0;
    repeat (5) @(posedge i_ref_clk);
    check(enc_sink.seen.size() + dec_sink.seen.size(), 0);
  endtask

  initial begin
    repeat (8) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    i_rst_n = 1'b1;
    t_enc_stall();
    t_enc_inserts();
    t_dec(1'b0);
    t_dec(1'b1);
    t_clk_en_low();
    test_done();
  end

  initial begin
    #(25.0 * 20000);
    bad_count++;
    test_done();
  end
endmodule
